// ==== hdl/dual_event_counter_timer.sv ====
`timescale 1ns/1ps
`include "tally_consts.svh"

// Notes on behaviour
// - Two counters; index picks which is configured
// - Increment event chosen by increment source select
// - Increment signal qualified by programmable sense
// - Start event when count reaches delay
// - End event when count reaches duration
// - Trigger and clear source mutually exclusive
// - Counter begins counting on trigger event
// - Trigger signal qualified by programmable sense
// - Clear event resets counter; it keeps counting if an increment source is set
// - Clear signal qualified by programmable sense
// - Live count of selected counter readable
// - Count before clear captured for readback
// - Status of selected counter readable
module dual_event_counter_timer
  import tally_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  line_in,        // External line inputs
  input  wire logic [3:0]  user_out_in,    // User output levels
  input  wire logic [1:0]  logic_block_in, // Logic block outputs
  input  wire logic        exposure_start, // Exposure start level
  input  wire logic        exposure_end,   // Exposure end level
  input  wire logic        frame_wait,     // Frame trigger wait level
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       start_event_ff, // Counter start pulses
  output logic [1:0]       end_event_ff    // Counter end pulses
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Qualify a source level against a sense mode
  function automatic logic qualify(input logic cur, input logic prv, input sense_t s);
    case (s)
      SENSE_LEVEL_LOW:  qualify = !cur;
      SENSE_LEVEL_HIGH: qualify = cur;
      SENSE_FALLING:    qualify = prv && !cur;
      SENSE_RISING:     qualify = !prv && cur;
      SENSE_ANY:        qualify = prv != cur;
      default:          qualify = 1'b0;
    endcase
  endfunction
  // Merge new write data under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = be[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  logic                idx_ff;                 // Selected counter
  src_t                inc_src_ff    [2];      // Increment source
  sense_t              inc_sense_ff  [2];      // Increment sense
  src_t                trig_src_ff   [2];      // Trigger source
  sense_t              trig_sense_ff [2];      // Trigger sense
  src_t                clr_src_ff    [2];      // Clear source
  sense_t              clr_sense_ff  [2];      // Clear sense
  logic [`CNT_W-1:0]   delay_ff      [2];      // Start delay count
  logic [`CNT_W-1:0]   dur_ff        [2];      // End duration count
  logic [`CNT_W-1:0]   count_ff      [2];      // Live counts
  logic [`CNT_W-1:0]   captured_ff   [2];      // Count at clear
  tally_state_t        state_ff      [2];      // Operating states

  // ----------------------------------------------------------------
  // Event source vector and 1 MHz tick
  // ----------------------------------------------------------------
  logic [5:0]  tick_cnt_ff;   // Tick divider
  logic        tick_ff;       // One-cycle tick pulse
  logic [18:0] src_vec;       // Indexed by src_t
  logic [18:0] src_prev_ff;   // Previous levels for edge sense
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_ff <= 6'h00;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 6'(`TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 6'h00;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 6'h01;
      tick_ff     <= 1'b0;
    end
  end

  // Counter events route back so counters can chain
  assign src_vec = {frame_wait, exposure_end, exposure_start, logic_block_in,
                    end_event_ff, start_event_ff, user_out_in, line_in,
                    tick_ff, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) src_prev_ff <= 19'h0_0000;
    else          src_prev_ff <= src_vec;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic        aw_ok_ff, w_ok_ff;     // Address and data captured
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        do_write;
  logic        wr_hit;
  assign do_write = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0; w_ok_ff <= 1'b0; s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= `RESP_OKAY;
      aw_addr_ff <= 8'h00; w_data_ff <= 32'h0000_0000; w_strb_ff <= 4'h0;
    end else begin
      s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !w_ok_ff && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1; aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1; w_data_ff <= s_axi_wdata; w_strb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_ok_ff <= 1'b0; w_ok_ff <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable addresses
  always_comb begin
    if (aw_addr_ff == `OFS_INDEX) wr_hit = 1'b1;
    else if (aw_addr_ff >= `OFS_INC_SRC && aw_addr_ff <= `OFS_CLR_SENSE
             && aw_addr_ff[1:0] == 2'h0) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end

  // ----------------------------------------------------------------
  // Configuration writes, applied to the indexed counter
  // ----------------------------------------------------------------
  logic [31:0] wv;   // Merged write value
  assign wv = merge(32'h0000_0000, w_data_ff, w_strb_ff);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_ff <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        inc_src_ff[i] <= SRC_OFF;    inc_sense_ff[i]  <= SENSE_RISING;
        trig_src_ff[i] <= SRC_OFF;   trig_sense_ff[i] <= SENSE_RISING;
        clr_src_ff[i] <= SRC_OFF;    clr_sense_ff[i]  <= SENSE_RISING;
        delay_ff[i] <= `RST_COUNT;   dur_ff[i]        <= `RST_COUNT;
      end
    end else if (do_write) begin
      if (aw_addr_ff == `OFS_INDEX && w_strb_ff[0]) idx_ff <= w_data_ff[0];
      else if (aw_addr_ff == `OFS_INC_SRC) inc_src_ff[idx_ff] <= src_t'(wv[4:0]);
      else if (aw_addr_ff == `OFS_INC_SENSE) inc_sense_ff[idx_ff] <= sense_t'(wv[2:0]);
      else if (aw_addr_ff == `OFS_DELAY)
        delay_ff[idx_ff] <= merge(delay_ff[idx_ff], w_data_ff, w_strb_ff);
      else if (aw_addr_ff == `OFS_DURATION)
        dur_ff[idx_ff] <= merge(dur_ff[idx_ff], w_data_ff, w_strb_ff);
      else if (aw_addr_ff == `OFS_TRIG_SRC) begin
        trig_src_ff[idx_ff] <= src_t'(wv[4:0]);
        if (wv[4:0] != 5'h00) clr_src_ff[idx_ff] <= SRC_OFF;
      end else if (aw_addr_ff == `OFS_TRIG_SENSE) trig_sense_ff[idx_ff] <= sense_t'(wv[2:0]);
      else if (aw_addr_ff == `OFS_CLR_SRC) begin
        clr_src_ff[idx_ff] <= src_t'(wv[4:0]);
        if (wv[4:0] != 5'h00) trig_src_ff[idx_ff] <= SRC_OFF;
      end else if (aw_addr_ff == `OFS_CLR_SENSE) clr_sense_ff[idx_ff] <= sense_t'(wv[2:0]);
    end
  end

  // ----------------------------------------------------------------
  // Per-counter engines
  // ----------------------------------------------------------------
  logic [1:0] inc_hit, trig_hit, clr_hit, arm_hit; // Qualified events, trigger arming
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      arm_hit[i]  = do_write && aw_addr_ff == `OFS_TRIG_SRC && idx_ff == 1'(i)
                    && wv[4:0] != 5'h00;
      inc_hit[i]  = (inc_src_ff[i] != SRC_OFF) && qualify(src_vec[inc_src_ff[i]],
                    src_prev_ff[inc_src_ff[i]], inc_sense_ff[i]);
      trig_hit[i] = (trig_src_ff[i] != SRC_OFF) && qualify(src_vec[trig_src_ff[i]],
                    src_prev_ff[trig_src_ff[i]], trig_sense_ff[i]);
      clr_hit[i]  = (clr_src_ff[i] != SRC_OFF) && qualify(src_vec[clr_src_ff[i]],
                    src_prev_ff[clr_src_ff[i]], clr_sense_ff[i]);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2; i++) begin
        state_ff[i] <= ST_IDLE; count_ff[i] <= 32'h0000_0000;
        captured_ff[i] <= 32'h0000_0000;
        start_event_ff[i] <= 1'b0; end_event_ff[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        start_event_ff[i] <= 1'b0;
        end_event_ff[i]   <= 1'b0;
        if (clr_hit[i]) begin
          captured_ff[i] <= count_ff[i];
          count_ff[i]    <= 32'h0000_0000;
          state_ff[i]    <= (inc_src_ff[i] == SRC_OFF) ? ST_IDLE : ST_ACTIVE;
        end else if (arm_hit[i]) state_ff[i] <= ST_TRIG_WAIT;
        else begin
          case (state_ff[i])
            ST_IDLE: begin
              // Trigger source arms the counter; otherwise count freely
              if (trig_src_ff[i] != SRC_OFF) state_ff[i] <= ST_TRIG_WAIT;
              else if (inc_src_ff[i] != SRC_OFF) state_ff[i] <= ST_ACTIVE;
            end
            ST_TRIG_WAIT: begin
              if (trig_hit[i]) begin
                count_ff[i] <= 32'h0000_0000;
                state_ff[i] <= ST_ACTIVE;
              end else if (trig_src_ff[i] == SRC_OFF) state_ff[i] <= ST_IDLE;
            end
            ST_ACTIVE: begin
              if (inc_hit[i]) begin
                count_ff[i] <= count_ff[i] + 32'h0000_0001;
                if (count_ff[i] == 32'hFFFF_FFFF) state_ff[i] <= ST_OVERFLOW;
                else begin
                  if (count_ff[i] + 32'h0000_0001 == delay_ff[i])
                    start_event_ff[i] <= 1'b1;
                  if (count_ff[i] + 32'h0000_0001 == dur_ff[i]) begin
                    end_event_ff[i] <= 1'b1;
                    state_ff[i]     <= ST_COMPLETED;
                  end
                end
              end
            end
            default: begin
              // Completed or overflow: rearm on a fresh trigger here; clear events are handled above
              if (trig_hit[i]) begin
                count_ff[i] <= 32'h0000_0000;
                state_ff[i] <= ST_ACTIVE;
              end
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [7:0]  ra;
  assign ra = s_axi_araddr;
  always_comb begin
    rd_hit = 1'b1;
    if (ra == `OFS_INDEX) rd_val = {31'h0, idx_ff};
    else if (ra == `OFS_INC_SRC) rd_val = {27'h0, inc_src_ff[idx_ff]};
    else if (ra == `OFS_INC_SENSE) rd_val = {29'h0, inc_sense_ff[idx_ff]};
    else if (ra == `OFS_DELAY) rd_val = delay_ff[idx_ff];
    else if (ra == `OFS_DURATION) rd_val = dur_ff[idx_ff];
    else if (ra == `OFS_TRIG_SRC) rd_val = {27'h0, trig_src_ff[idx_ff]};
    else if (ra == `OFS_TRIG_SENSE) rd_val = {29'h0, trig_sense_ff[idx_ff]};
    else if (ra == `OFS_CLR_SRC) rd_val = {27'h0, clr_src_ff[idx_ff]};
    else if (ra == `OFS_CLR_SENSE) rd_val = {29'h0, clr_sense_ff[idx_ff]};
    else if (ra == `OFS_LIVE) rd_val = count_ff[idx_ff];
    else if (ra == `OFS_CAPTURED) rd_val = captured_ff[idx_ff];
    else if (ra == `OFS_STATE) rd_val = {29'h0, state_ff[idx_ff]};
    else if (ra == `OFS_EVENTS_IN) rd_val = {13'h0, src_vec};
    else begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000; s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1; s_axi_rdata <= rd_val;
        s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_clear_captures: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_hit[0] |=> captured_ff[0] == $past(count_ff[0]) && count_ff[0] == 32'h0)
    else $error("capture on clear wrong");
  chk_trigger_starts: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff[0] == ST_TRIG_WAIT && trig_hit[0] && !clr_hit[0] && !arm_hit[0]
    |=> state_ff[0] == ST_ACTIVE)
    else $error("trigger did not start counter");
  chk_start_reach: assert property (@(posedge aclk) disable iff (!aresetn)
    start_event_ff[0] |-> count_ff[0] == delay_ff[0] || $past(clr_hit[0]))
    else $error("start event at wrong count");
  chk_end_reach: assert property (@(posedge aclk) disable iff (!aresetn)
    end_event_ff[0] |-> state_ff[0] == ST_COMPLETED && count_ff[0] == dur_ff[0])
    else $error("end event without completion");
  chk_excl_sources: assert property (@(posedge aclk) disable iff (!aresetn)
    !(trig_src_ff[0] != SRC_OFF && clr_src_ff[0] != SRC_OFF))
    else $error("trigger and clear both active");
  chk_incr_step: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff[1] == ST_ACTIVE && inc_hit[1] && !clr_hit[1] && !arm_hit[1]
    |=> count_ff[1] == $past(count_ff[1]) + 32'h1)
    else $error("count did not step");
  chk_wrap_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff[0] == ST_ACTIVE && inc_hit[0] && !clr_hit[0] && count_ff[0] == 32'hFFFF_FFFF
    && !arm_hit[0] |=> state_ff[0] == ST_OVERFLOW)
    else $error("overflow not flagged");
  chk_rise_sense: assert property (@(posedge aclk) disable iff (!aresetn)
    inc_sense_ff[0] == SENSE_RISING && inc_hit[0]
    |-> src_vec[inc_src_ff[0]] && !src_prev_ff[inc_src_ff[0]])
    else $error("rising sense misqualified");
endmodule

// ==== common/tally_consts.svh ====
`ifndef TALLY_CONSTS_SVH
`define TALLY_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_INDEX      8'h00
`define OFS_INC_SRC    8'h04
`define OFS_INC_SENSE  8'h08
`define OFS_DELAY      8'h0C
`define OFS_DURATION   8'h10
`define OFS_TRIG_SRC   8'h14
`define OFS_TRIG_SENSE 8'h18
`define OFS_CLR_SRC    8'h1C
`define OFS_CLR_SENSE  8'h20
`define OFS_LIVE       8'h24
`define OFS_CAPTURED   8'h28
`define OFS_STATE      8'h2C
`define OFS_EVENTS_IN  8'h30

// ----------------------------------------------------------------
// Field widths, reset values and timing
// ----------------------------------------------------------------
`define SRC_W          5
`define SENSE_W        3
`define CNT_W          32
`define RST_SENSE      3'h3
`define RST_COUNT      32'h0000_0001
`define CLK_HZ         50000000
`define TICK_HZ        1000000
`define TICK_CYCLES    (`CLK_HZ / `TICK_HZ)
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ==== common/tally_pkg.sv ====
package tally_pkg;

  // Event sources, shared by increment, trigger and clear selects
  typedef enum logic [4:0] {
    SRC_OFF, SRC_TICK, SRC_LINE0, SRC_LINE1, SRC_LINE2, SRC_LINE3,
    SRC_USER0, SRC_USER1, SRC_USER2, SRC_USER3,
    SRC_C0_START, SRC_C1_START, SRC_C0_END, SRC_C1_END,
    SRC_LOGIC0, SRC_LOGIC1, SRC_EXP_START, SRC_EXP_END, SRC_FRAME_WAIT
  } src_t;

  // Signal sense qualifiers
  typedef enum logic [2:0] {
    SENSE_LEVEL_LOW, SENSE_LEVEL_HIGH, SENSE_FALLING, SENSE_RISING, SENSE_ANY
  } sense_t;

  // Counter operating states
  typedef enum logic [2:0] {
    ST_IDLE, ST_TRIG_WAIT, ST_ACTIVE, ST_COMPLETED, ST_OVERFLOW
  } tally_state_t;

endpackage

// ==== dv/test_dual_event_counter_timer.sv ====
`timescale 1ns/1ps
`include "tally_consts.svh"

// Compares one value against its expectation and keeps the tallies
`define CHECK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module test_dual_event_counter_timer
  import tally_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [1:0]  resp;
  } exp_t;
  logic        aclk           = 1'b0;  // Bus clock
  logic        aresetn        = 1'b0;  // Held low for 20 cycles
  logic [3:0]  line_in        = 4'h0;  // Driven by the scenarios
  logic [3:0]  user_out_in    = 4'h0;  // Random background levels
  logic [1:0]  logic_block_in = 2'h0;
  logic        exposure_start = 1'b0;
  logic        exposure_end   = 1'b0;
  logic        frame_wait     = 1'b0;
  logic [7:0]  s_axi_awaddr   = 8'h00;
  logic        s_axi_awvalid  = 1'b0;
  logic [31:0] s_axi_wdata    = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb    = 4'hF;
  logic        s_axi_wvalid   = 1'b0;
  logic        s_axi_bready   = 1'b0;
  logic [7:0]  s_axi_araddr   = 8'h00;
  logic        s_axi_arvalid  = 1'b0;
  logic        s_axi_rready   = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0]  start_event_ff, end_event_ff;
  exp_t        rq[$];                  // Notes for pending reads
  exp_t        wq[$];                  // Notes for pending writes
  exp_t        re, we;                 // Oldest notes taken off
  int          errors         = 0;
  int          checks_done    = 0;
  int          seed           = 9;
  int          start_n[2]     = '{0, 0}; // Start pulses seen per counter
  int          end_n[2]       = '{0, 0}; // End pulses seen per counter
  logic [31:0] rv;                     // Random register value

  // ----------------------------------------------------------------
  // Clock, design and watchers
  // ----------------------------------------------------------------
  always #10 aclk = ~aclk;

  dual_event_counter_timer u_dual_event_counter_timer (
    .aclk(aclk), .aresetn(aresetn), .line_in(line_in), .user_out_in(user_out_in),
    .logic_block_in(logic_block_in), .exposure_start(exposure_start),
    .exposure_end(exposure_end), .frame_wait(frame_wait),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .start_event_ff(start_event_ff), .end_event_ff(end_event_ff)
  );

  // Unselected event inputs wander so that a wrong select shows up
  always @(posedge aclk) begin
    user_out_in    <= 4'($random(seed));
    logic_block_in <= 2'($random(seed));
    exposure_start <= 1'($random(seed));
    exposure_end   <= 1'($random(seed));
    frame_wait     <= 1'($random(seed));
  end

  // Takes the oldest note whenever a response is handed over, counts pulses
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      re = rq.pop_front();
      `CHECK($sformatf("rdata at %0h", re.addr), re.data, s_axi_rdata)
      `CHECK($sformatf("rresp at %0h", re.addr), re.resp, s_axi_rresp)
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
      we = wq.pop_front();
      `CHECK($sformatf("bresp at %0h", we.addr), we.resp, s_axi_bresp)
    end
    for (int i = 0; i < 2; i++) begin
      if (start_event_ff[i] === 1'b1) start_n[i]++;
      if (end_event_ff[i] === 1'b1) end_n[i]++;
    end
  end

  // ----------------------------------------------------------------
  // Bus and line tasks
  // ----------------------------------------------------------------
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    wq.push_back('{a, d, er});
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  // Read: note the expected word, hold the request until it is taken
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    rq.push_back('{a, ed, er});
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, `RESP_OKAY);
  endtask

  task automatic exp(input logic [7:0] a, input logic [31:0] d);
    rd(a, d, `RESP_OKAY);
  endtask

  // Sets one line and lets the qualifiers settle
  task automatic line_set(input int i, input logic v);
    @(posedge aclk);
    line_in[i] <= v;
    repeat (5) @(posedge aclk);
  endtask

  task automatic bump(input int i);
    line_set(i, 1'b1);
    line_set(i, 1'b0);
  endtask

  // Prints the tallies and the verdict, then stops
  task automatic results;
    $display("Checks done %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge aclk);
    errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values of both counters
    for (int c = 0; c < 2; c++) begin
      cfg(`OFS_INDEX, 32'(c));
      exp(`OFS_INDEX, 32'(c));
      exp(`OFS_INC_SRC, 32'(SRC_OFF));
      exp(`OFS_INC_SENSE, 32'(`RST_SENSE));
      exp(`OFS_DELAY, `RST_COUNT);
      exp(`OFS_DURATION, `RST_COUNT);
      exp(`OFS_TRIG_SRC, 32'(SRC_OFF));
      exp(`OFS_CLR_SRC, 32'(SRC_OFF));
      exp(`OFS_LIVE, 32'h0000_0000);
      exp(`OFS_CAPTURED, 32'h0000_0000);
      exp(`OFS_STATE, 32'(ST_IDLE));
    end
    // Refused accesses and random values held on counter 1
    rd(8'h34, 32'h0000_0000, `RESP_SLVERR);
    wr(`OFS_LIVE, 32'h0000_00FF, `RESP_SLVERR);
    wr(`OFS_STATE, 32'h0000_0001, `RESP_SLVERR);
    exp(`OFS_LIVE, 32'h0000_0000);
    repeat (4) begin
      rv = $random(seed);
      cfg(`OFS_DELAY, rv);
      exp(`OFS_DELAY, rv);
    end
    cfg(`OFS_DELAY, 32'h0000_0064);
    cfg(`OFS_DURATION, 32'h0000_0064);
    // Trigger and clear sources exclude each other on counter 0
    cfg(`OFS_INDEX, 32'h0000_0000);
    cfg(`OFS_TRIG_SRC, 32'(SRC_LINE3));
    cfg(`OFS_CLR_SRC, 32'(SRC_LINE2));
    exp(`OFS_TRIG_SRC, 32'(SRC_OFF));
    cfg(`OFS_TRIG_SRC, 32'(SRC_LINE3));
    exp(`OFS_CLR_SRC, 32'(SRC_OFF));
    exp(`OFS_TRIG_SRC, 32'(SRC_LINE3));
    cfg(`OFS_TRIG_SRC, 32'(SRC_OFF));
    // Free counting on rising edges of line 0, delay 3, duration 5
    cfg(`OFS_DELAY, 32'h0000_0003);
    cfg(`OFS_DURATION, 32'h0000_0005);
    cfg(`OFS_INC_SRC, 32'(SRC_LINE0));
    bump(0);
    bump(0);
    `CHECK("start pulses", 0, start_n[0])
    bump(0);
    `CHECK("start pulses", 1, start_n[0])
    `CHECK("end pulses", 0, end_n[0])
    exp(`OFS_STATE, 32'(ST_ACTIVE));
    bump(0);
    bump(0);
    `CHECK("end pulses", 1, end_n[0])
    exp(`OFS_LIVE, 32'h0000_0005);
    exp(`OFS_STATE, 32'(ST_COMPLETED));
    cfg(`OFS_INDEX, 32'h0000_0001);
    exp(`OFS_LIVE, 32'h0000_0000);
    // Every increment sense on counter 1, cleared by line 2 each time
    for (int s = 0; s < 5; s++) begin
      cfg(`OFS_INC_SRC, 32'(SRC_OFF));
      line_set(1, (s == 0));
      cfg(`OFS_INC_SENSE, 32'(s));
      cfg(`OFS_INC_SRC, 32'(SRC_LINE1));
      if (s > 1) bump(1);
      else repeat (10) @(posedge aclk);
      rv = (s == 4) ? 32'h0000_0002 : ((s > 1) ? 32'h0000_0001 : 32'h0000_0000);
      exp(`OFS_LIVE, rv);
      cfg(`OFS_CLR_SRC, 32'(SRC_LINE2));
      bump(2);
      exp(`OFS_CAPTURED, rv);
      exp(`OFS_LIVE, 32'h0000_0000);
      cfg(`OFS_CLR_SRC, 32'(SRC_OFF));
    end
    // Counter 1 counts the end events of counter 0
    cfg(`OFS_INC_SENSE, 32'(SENSE_RISING));
    cfg(`OFS_INC_SRC, 32'(SRC_C0_END));
    // Falling-edge clear of counter 0
    cfg(`OFS_INDEX, 32'h0000_0000);
    cfg(`OFS_CLR_SENSE, 32'(SENSE_FALLING));
    cfg(`OFS_CLR_SRC, 32'(SRC_LINE2));
    line_set(2, 1'b1);
    exp(`OFS_LIVE, 32'h0000_0005);
    line_set(2, 1'b0);
    exp(`OFS_CAPTURED, 32'h0000_0005);
    exp(`OFS_LIVE, 32'h0000_0000);
    // Falling-edge trigger of counter 0 from line 3
    cfg(`OFS_TRIG_SENSE, 32'(SENSE_FALLING));
    cfg(`OFS_TRIG_SRC, 32'(SRC_LINE3));
    line_set(3, 1'b1);
    bump(0);
    exp(`OFS_LIVE, 32'h0000_0000);
    exp(`OFS_STATE, 32'(ST_TRIG_WAIT));
    line_set(3, 1'b0);
    repeat (5) bump(0);
    exp(`OFS_LIVE, 32'h0000_0005);
    `CHECK("start pulses", 2, start_n[0])
    `CHECK("end pulses", 2, end_n[0])
    cfg(`OFS_INDEX, 32'h0000_0001);
    exp(`OFS_LIVE, 32'h0000_0001);
    `CHECK("start pulses c1", 0, start_n[1])
    `CHECK("end pulses c1", 0, end_n[1])
    repeat (4) @(posedge aclk);
    results();
  end

endmodule
